/* File: common/port_pad_pkg.sv */
/*
  Shared constants and types for the port pad configuration block:
  register offsets, writable-bit masks, field positions, reset values,
  the bus state type and the register select type.
  Assumes one 32-bit word per register; only the low byte is used.
*/
package port_pad_pkg;

  // byte offsets of the registers on the bus
  localparam logic [7:0] OFS_PA_DATA = 8'h00;
  localparam logic [7:0] OFS_PB_DATA = 8'h04;
  localparam logic [7:0] OFS_PA_DIR = 8'h08;
  localparam logic [7:0] OFS_PB_DIR = 8'h0c;
  localparam logic [7:0] OFS_PE_DATA = 8'h10;
  localparam logic [7:0] OFS_PE_DIR = 8'h14;
  localparam logic [7:0] OFS_PULLUP = 8'h18;
  localparam logic [7:0] OFS_DRIVE = 8'h1c;
  localparam logic [7:0] OFS_PK_DATA = 8'h20;
  localparam logic [7:0] OFS_PK_DIR = 8'h24;

  // implemented bits of each register; the others read zero, except port e data bits 1..0, which read the pin level
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_PE_DIR = 8'hfc;
  localparam logic [7:0] MASK_PE_DATA = 8'hfc;
  localparam logic [7:0] MASK_PK = 8'hbf;
  localparam logic [7:0] MASK_PULLUP = 8'hd3;
  localparam logic [7:0] MASK_PULLUP_DEBUG = 8'h40;
  localparam logic [7:0] MASK_DRIVE = 8'h93;
  localparam logic [7:0] MASK_PE_PULLDOWN = 8'h60;

  // field positions in the pull-up and drive registers
  localparam int unsigned BIT_PK_PULLUP = 7;
  localparam int unsigned BIT_DEBUG_PULLUP = 6;
  localparam int unsigned BIT_PE_PULLUP = 4;
  localparam int unsigned BIT_PB_PULLUP = 1;
  localparam int unsigned BIT_PA_PULLUP = 0;
  localparam int unsigned BIT_PK_WEAK = 7;
  localparam int unsigned BIT_PE_WEAK = 4;
  localparam int unsigned BIT_PB_WEAK = 1;
  localparam int unsigned BIT_PA_WEAK = 0;

  // reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h00000000;

  // data-phase tracking of the bus slave
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } bus_state_t;

  // decoded register selection
  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_PA_DATA,
    SEL_PB_DATA,
    SEL_PA_DIR,
    SEL_PB_DIR,
    SEL_PE_DATA,
    SEL_PE_DIR,
    SEL_PULLUP,
    SEL_DRIVE,
    SEL_PK_DATA,
    SEL_PK_DIR
  } reg_sel_t;

endpackage

/* File: testbench/port_pad_properties.sv */
/*
  Port-level checks for the pad configuration block.
  Assumes one clock, sys_clk, and the async active-low reset nrst.
*/
`timescale 1ns/10ps
`default_nettype none

module port_pad_properties
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [7:0] pa_periph_drive,
  input wire logic [7:0] pa_oe_n,
  input wire logic [7:0] pa_pullup,
  input wire logic [7:0] pa_reduced,
  input wire logic [7:0] pe_oe_n,
  input wire logic [7:0] pe_pullup,
  input wire logic [7:0] pe_pulldown,
  input wire logic [7:0] pk_periph_drive,
  input wire logic [7:0] pk_oe_n,
  input wire logic [7:0] pk_pullup,
  input wire logic debug_pin_drive,
  input wire logic debug_pin_pullup
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // address phase accepted by the slave
  wire logic take;
  assign take = hsel & htrans[1] & hready;

  // bus timing: one wait state on reads, none on writes
  property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read data phase timing wrong");
  property p_wr_ready; take && hwrite |=> hreadyout; endproperty
  a_wr_ready: assert property (p_wr_ready)
    else $error("write data phase stalled");
  // pins 1..0 of port e never drive
  property p_pe_low_in; pe_oe_n[1:0] == 2'b11; endproperty
  a_pe_low_in: assert property (p_pe_low_in)
    else $error("port e low pins driving");
  // pull-up only on pins that are inputs, and on all of them together
  property p_pa_pu_out; (pa_pullup & (~pa_oe_n | pa_periph_drive)) == 8'h00;
  endproperty
  a_pa_pu_out: assert property (p_pa_pu_out)
    else $error("port a pull-up on an output");
  property p_pa_pu_all;
    pa_pullup != 8'h00 |-> pa_pullup == (pa_oe_n & ~pa_periph_drive);
  endproperty
  a_pa_pu_all: assert property (p_pa_pu_all)
    else $error("port a pull-up missing on an input");
  property p_pk_pu;
    pk_pullup != 8'h00 |-> pk_pullup == (pk_oe_n & ~pk_periph_drive & 8'hbf);
  endproperty
  a_pk_pu: assert property (p_pk_pu)
    else $error("port k pull-up pattern wrong");
  property p_pe_pu; pe_pullup[6:5] == 2'b00; endproperty
  a_pe_pu: assert property (p_pe_pu)
    else $error("port e pins 6..5 pulled up");
  property p_pe_pd; pe_pulldown == 8'h00; endproperty
  a_pe_pd: assert property (p_pe_pd)
    else $error("port e pull-down on out of reset");
  // reduced drive only on pins that drive
  property p_pa_rd; (pa_reduced & pa_oe_n & ~pa_periph_drive) == 8'h00;
  endproperty
  a_pa_rd: assert property (p_pa_rd)
    else $error("port a reduced drive on an input");
  property p_pa_rd_all;
    pa_reduced != 8'h00 |-> pa_reduced == (~pa_oe_n | pa_periph_drive);
  endproperty
  a_pa_rd_all: assert property (p_pa_rd_all)
    else $error("port a reduced drive pattern wrong");
  property p_dbg; debug_pin_pullup |-> !debug_pin_drive; endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug pin pull-up while driven");
endmodule

bind port_pad_config_regs port_pad_properties i_props (
  .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .pa_periph_drive(pa_periph_drive), .pa_oe_n(pa_oe_n),
  .pa_pullup(pa_pullup), .pa_reduced(pa_reduced), .pe_oe_n(pe_oe_n),
  .pe_pullup(pe_pullup), .pe_pulldown(pe_pulldown),
  .pk_periph_drive(pk_periph_drive), .pk_oe_n(pk_oe_n),
  .pk_pullup(pk_pullup), .debug_pin_drive(debug_pin_drive),
  .debug_pin_pullup(debug_pin_pullup)
);

`default_nettype wire

/* File: testbench/tb_top.sv */
/*
  Self-checking bench for the pad configuration block.
  Assumes the slave is alone on the bus, so hready is its hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import port_pad_pkg::*;
  `define CHK(a, e) check_val(32'(a), 32'(e))

  logic sys_clk, nrst, hsel, hwrite, single_chip_mode, special_single_chip;
  logic debug_pin_drive;
  logic [31:0] haddr, hwdata, rdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pa_periph_drive, pb_periph_drive, pe_periph_drive;
  logic [7:0] pk_periph_drive, pa_in, pb_in, pe_in, pk_in;
  wire logic hreadyout, hresp, debug_pin_pullup;
  wire logic [31:0] hrdata;
  wire logic [7:0] pa_out, pa_oe_n, pa_pullup, pa_reduced;
  wire logic [7:0] pb_out, pb_oe_n, pb_pullup, pb_reduced;
  wire logic [7:0] pe_out, pe_oe_n, pe_pullup, pe_pulldown, pe_reduced;
  wire logic [7:0] pk_out, pk_oe_n, pk_pullup, pk_reduced;
  int mismatches, check_count, cycles;

  port_pad_config_regs i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .single_chip_mode(single_chip_mode),
    .special_single_chip(special_single_chip),
    .pa_periph_drive(pa_periph_drive), .pb_periph_drive(pb_periph_drive),
    .pe_periph_drive(pe_periph_drive), .pk_periph_drive(pk_periph_drive),
    .debug_pin_drive(debug_pin_drive), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pa_pullup(pa_pullup), .pa_reduced(pa_reduced),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
    .pb_pullup(pb_pullup), .pb_reduced(pb_reduced), .pe_in(pe_in),
    .pe_out(pe_out), .pe_oe_n(pe_oe_n), .pe_pullup(pe_pullup),
    .pe_pulldown(pe_pulldown), .pe_reduced(pe_reduced), .pk_in(pk_in),
    .pk_out(pk_out), .pk_oe_n(pk_oe_n), .pk_pullup(pk_pullup),
    .pk_reduced(pk_reduced), .debug_pin_pullup(debug_pin_pullup)
  );

  // 50 ns bus clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // hang guard, far above the roughly 120 cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check_val(input logic [31:0] a, input logic [31:0] e);
    check_count++;
    if (a !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  // looks just before each edge, so it sees what the edge samples;
  // a slave that never answers is left to the cycle guard
  task automatic wait_ready;
    @(negedge sys_clk);
    while (hreadyout !== 1'b1)
      @(negedge sys_clk);
    rdata = hrdata;
    @(posedge sys_clk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    wait_ready();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rdata, {24'h000000, e});
  endtask

  task automatic t_reset;
    `CHK(pe_pulldown, 8'h00);
    `CHK(pa_oe_n, 8'hff);
    rd_chk(OFS_PE_DIR, RST_DIR);
    rd_chk(OFS_PULLUP, RST_PULLUP);
    rd_chk(OFS_DRIVE, RST_DRIVE);
  endtask

  task automatic t_pe_dir;
    bus(1'b1, OFS_PE_DIR, 8'hff);
    @(negedge sys_clk);
    `CHK(pe_oe_n, 8'h03);
    rd_chk(OFS_PE_DIR, 8'hfc);
    bus(1'b1, OFS_PE_DIR, 8'h24);
    @(negedge sys_clk);
    `CHK(pe_oe_n, 8'hdb);
    rd_chk(OFS_PE_DIR, 8'h24);
    bus(1'b1, OFS_PE_DIR, 8'h00);
  endtask

  // debug bit locked outside special single-chip mode
  task automatic t_pullup;
    bus(1'b1, OFS_PULLUP, 8'hff);
    @(negedge sys_clk);
    `CHK(pa_pullup, 8'hff);
    `CHK(pb_pullup, 8'hff);
    `CHK(pe_pullup, 8'h9f);
    `CHK(pk_pullup, 8'hbf);
    `CHK(debug_pin_pullup, 1'b0);
    rd_chk(OFS_PULLUP, 8'h93);
    @(posedge sys_clk);
    special_single_chip <= 1'b1;
    bus(1'b1, OFS_PULLUP, 8'hff);
    @(negedge sys_clk);
    `CHK(debug_pin_pullup, 1'b1);
    rd_chk(OFS_PULLUP, 8'hd3);
    @(posedge sys_clk);
    debug_pin_drive <= 1'b1;
    single_chip_mode <= 1'b0;
    @(negedge sys_clk);
    `CHK(debug_pin_pullup, 1'b0);
    rd_chk(OFS_PULLUP, 8'h00);
    @(posedge sys_clk);
    single_chip_mode <= 1'b1;
    debug_pin_drive <= 1'b0;
    special_single_chip <= 1'b0;
    bus(1'b1, OFS_PULLUP, 8'h00);
    @(negedge sys_clk);
    `CHK(pa_pullup, 8'h00);
    `CHK(debug_pin_pullup, 1'b1);
    rd_chk(OFS_PULLUP, 8'h40);
  endtask

  // mixed directions on ports a, e and k, peripheral drive on ports b and e
  task automatic t_drive;
    bus(1'b1, OFS_DRIVE, 8'hff);
    bus(1'b1, OFS_PULLUP, 8'h93);
    rd_chk(OFS_DRIVE, 8'h93);
    @(negedge sys_clk);
    `CHK(pa_reduced, 8'h00);
    bus(1'b1, OFS_PA_DIR, 8'h0f);
    bus(1'b1, OFS_PK_DIR, 8'h81);
    bus(1'b1, OFS_PE_DIR, 8'h10);
    @(posedge sys_clk);
    pb_periph_drive <= 8'h80;
    pe_periph_drive <= 8'h04;
    @(negedge sys_clk);
    `CHK(pa_reduced, 8'h0f);
    `CHK(pa_pullup, 8'hf0);
    `CHK(pb_reduced, 8'h80);
    `CHK(pb_pullup, 8'h7f);
    `CHK(pk_reduced, 8'h81);
    `CHK(pk_pullup, 8'h3e);
    `CHK(pe_reduced, 8'h14);
    `CHK(pe_pullup, 8'h8b);
    `CHK(pk_oe_n, 8'h7e);
    `CHK(pb_oe_n, 8'hff);
    bus(1'b1, OFS_DRIVE, 8'h00);
    @(negedge sys_clk);
    `CHK(pa_reduced, 8'h00);
  endtask

  // port a dir is 0x0f here: low nibble from register, high from pins
  task automatic t_data;
    @(posedge sys_clk);
    pa_in <= 8'h3c;
    bus(1'b1, OFS_PA_DATA, 8'ha5);
    @(negedge sys_clk);
    `CHK(pa_out, 8'ha5);
    rd_chk(OFS_PA_DATA, 8'h35);
    bus(1'b1, OFS_PB_DATA, 8'h5a);
    bus(1'b1, OFS_PE_DATA, 8'hff);
    bus(1'b1, OFS_PK_DATA, 8'hff);
    @(negedge sys_clk);
    `CHK(pb_out, 8'h5a);
    `CHK(pe_out, 8'hfc);
    `CHK(pk_out, 8'hbf);
    rd_chk(OFS_PK_DATA, 8'h81);
    bus(1'b1, 8'h28, 8'hff);
    rd_chk(8'h28, 8'h00);
    `CHK(hresp, 1'b0);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial
  begin
    {nrst, hsel, hwrite, special_single_chip, debug_pin_drive} = 5'h00;
    single_chip_mode = 1'b1;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = 3'h2;
    {pa_periph_drive, pb_periph_drive} = 16'h0000;
    {pe_periph_drive, pk_periph_drive} = 16'h0000;
    {pa_in, pb_in, pe_in, pk_in} = 32'h005aff00;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk);
    `CHK(pe_pulldown, 8'h60);
    nrst <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_pe_dir();
    t_pullup();
    t_drive();
    t_data();
    report_and_stop();
  end
endmodule

`default_nettype wire

/* File: verilog/port_pad_config_regs.sv */
/*
  Pad configuration for ports a, b, e, k and the debug pin: direction,
  data, pull-up enables and reduced drive, reached over AHB-Lite.
  Assumes the pad ring resolves pin levels from out and oe_n, and that
  mode and peripheral-drive inputs come from logic on sys_clk.
*/
// What this block does
// - port e direction bits 7..2: one makes pin output, zero input
// - port e direction register writable and readable at any time
// - pull-up bit 7 enables pull-ups on port k input pins
// - pull-up enables never act on pins that are outputs
// - pull-up bit 6 enables debug pin pull-up while it is input
// - debug pull-up bit written only in special single-chip mode
// - pull-up bit 4 covers port e inputs except pins 5 and 6
// - port e pins 5 and 6 pull-downs on only during reset
// - pull-up bit 1 enables pull-ups on port b input pins
// - pull-up bit 0 enables pull-ups on port a input pins
// - pull-up register readable at any time in single-chip modes
// - drive bit 7 selects reduced drive on port k outputs
// - drive bit 4 selects reduced drive on port e outputs
// - drive bit 1 selects reduced drive on port b outputs
// - drive bit 0 selects reduced drive on port a outputs
// - reduced drive select never acts on pins that are inputs
// - drive selection holds for general and peripheral functions
// - data read returns register bit if output, pin level if input
`timescale 1ns/10ps
`default_nettype none

module port_pad_config_regs
  import port_pad_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // operating mode
  input wire logic single_chip_mode,
  input wire logic special_single_chip,
  // peripherals currently driving a pin through its alternate function
  input wire logic [7:0] pa_periph_drive,
  input wire logic [7:0] pb_periph_drive,
  input wire logic [7:0] pe_periph_drive,
  input wire logic [7:0] pk_periph_drive,
  input wire logic debug_pin_drive,
  // port a pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe_n,
  output logic [7:0] pa_pullup,
  output logic [7:0] pa_reduced,
  // port b pins
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe_n,
  output logic [7:0] pb_pullup,
  output logic [7:0] pb_reduced,
  // port e pins
  input wire logic [7:0] pe_in,
  output logic [7:0] pe_out,
  output logic [7:0] pe_oe_n,
  output logic [7:0] pe_pullup,
  output logic [7:0] pe_pulldown,
  output logic [7:0] pe_reduced,
  // port k pins
  input wire logic [7:0] pk_in,
  output logic [7:0] pk_out,
  output logic [7:0] pk_oe_n,
  output logic [7:0] pk_pullup,
  output logic [7:0] pk_reduced,
  // debug pin pad control
  output logic debug_pin_pullup
);

  // refuse address widths that cannot reach the register offsets
  generate
    if (ADDR_W < 8)
    begin : g_addr_check
      $error("port_pad_config_regs: ADDR_W must be at least 8");
    end
  endgenerate

  // word address decode; anything above the map selects nothing
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [7:0] ofs;
    logic high_zero;
    ofs = {a[7:2], 2'b00};
    high_zero = (a >> 8) == '0;
    decode = SEL_NONE;
    if (high_zero)
    begin
      unique case (ofs)
        OFS_PA_DATA: decode = SEL_PA_DATA;
        OFS_PB_DATA: decode = SEL_PB_DATA;
        OFS_PA_DIR: decode = SEL_PA_DIR;
        OFS_PB_DIR: decode = SEL_PB_DIR;
        OFS_PE_DATA: decode = SEL_PE_DATA;
        OFS_PE_DIR: decode = SEL_PE_DIR;
        OFS_PULLUP: decode = SEL_PULLUP;
        OFS_DRIVE: decode = SEL_DRIVE;
        OFS_PK_DATA: decode = SEL_PK_DATA;
        OFS_PK_DIR: decode = SEL_PK_DIR;
        default: decode = SEL_NONE;
      endcase
    end
  endfunction

  // register bit for outputs, synchronised pin level for inputs
  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] data,
                                           input logic [7:0] pin);
    port_read = (dir & data) | (~dir & pin);
  endfunction

  bus_state_t bus_state;
  bus_state_t next_bus_state;
  reg_sel_t sel_q;
  logic [7:0] pa_data, pb_data, pe_data, pk_data;
  logic [7:0] pa_dir, pb_dir, pe_dir, pk_dir;
  logic [7:0] pullup_ctrl_reg;
  logic [7:0] drive_strength_reg;
  logic [7:0] pa_meta, pb_meta, pe_meta, pk_meta;
  logic [7:0] pa_sync, pb_sync, pe_sync, pk_sync;

  // first synchroniser stage; only the second stage reads it
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pa_meta <= RST_DATA;
      pb_meta <= RST_DATA;
      pe_meta <= RST_DATA;
      pk_meta <= RST_DATA;
    end
    else
    begin
      pa_meta <= pa_in;
      pb_meta <= pb_in;
      pe_meta <= pe_in;
      pk_meta <= pk_in;
    end
  end

  // second stage; reads see a pin change two to three cycles late
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pa_sync <= RST_DATA;
      pb_sync <= RST_DATA;
      pe_sync <= RST_DATA;
      pk_sync <= RST_DATA;
    end
    else
    begin
      pa_sync <= pa_meta;
      pb_sync <= pb_meta;
      pe_sync <= pe_meta;
      pk_sync <= pk_meta;
    end
  end

  // bus handshake: reads take one wait state so hrdata is a flop
  wire accept = hsel && htrans[1] && hready;
  wire do_write = bus_state == BUS_WRITE;
  wire do_read = bus_state == BUS_READ_WAIT;

  always_comb
  begin
    next_bus_state = BUS_IDLE;
    unique case (bus_state)
      BUS_READ_WAIT: next_bus_state = BUS_READ_DONE;
      BUS_IDLE, BUS_WRITE, BUS_READ_DONE:
        if (accept)
          next_bus_state = hwrite ? BUS_WRITE : BUS_READ_WAIT;
    endcase
  end

  assign hreadyout = bus_state != BUS_READ_WAIT;
  assign hresp = 1'b0; // always okay, unmapped included

  // address phase capture and bus state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_state <= BUS_IDLE;
      sel_q <= SEL_NONE;
    end
    else
    begin
      bus_state <= next_bus_state;
      if (accept)
        sel_q <= decode(haddr);
    end
  end

  // one register's strobe; inputs passed in so assigns stay sensitive
  function automatic logic wr_strobe(input logic wr, input reg_sel_t cur,
                                     input reg_sel_t which);
    wr_strobe = wr && cur == which;
  endfunction

  // write strobes for the data phase
  wire wr_pa_data = wr_strobe(do_write, sel_q, SEL_PA_DATA);
  wire wr_pb_data = wr_strobe(do_write, sel_q, SEL_PB_DATA);
  wire wr_pa_dir = wr_strobe(do_write, sel_q, SEL_PA_DIR);
  wire wr_pb_dir = wr_strobe(do_write, sel_q, SEL_PB_DIR);
  wire wr_pe_data = wr_strobe(do_write, sel_q, SEL_PE_DATA);
  wire wr_pe_dir = wr_strobe(do_write, sel_q, SEL_PE_DIR);
  wire wr_pullup = wr_strobe(do_write, sel_q, SEL_PULLUP);
  wire wr_drive = wr_strobe(do_write, sel_q, SEL_DRIVE);
  wire wr_pk_data = wr_strobe(do_write, sel_q, SEL_PK_DATA);
  wire wr_pk_dir = wr_strobe(do_write, sel_q, SEL_PK_DIR);
  wire [7:0] wbyte = hwdata[7:0];

  // debug pull-up bit keeps its value outside special single-chip
  wire [7:0] debug_keep = special_single_chip ? wbyte : pullup_ctrl_reg;
  wire [7:0] next_pullup =
    (wbyte & MASK_PULLUP & ~MASK_PULLUP_DEBUG) |
    (debug_keep & MASK_PULLUP_DEBUG);

  // port data registers; masks drop unimplemented bits
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pa_data <= RST_DATA;
      pb_data <= RST_DATA;
      pe_data <= RST_DATA;
      pk_data <= RST_DATA;
    end
    else
    begin
      if (wr_pa_data) pa_data <= wbyte;
      if (wr_pb_data) pb_data <= wbyte;
      if (wr_pe_data) pe_data <= wbyte & MASK_PE_DATA;
      if (wr_pk_data) pk_data <= wbyte & MASK_PK;
    end
  end

  // direction registers, writable at any time
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pa_dir <= RST_DIR;
      pb_dir <= RST_DIR;
      pe_dir <= RST_DIR;
      pk_dir <= RST_DIR;
    end
    else
    begin
      if (wr_pa_dir) pa_dir <= wbyte;
      if (wr_pb_dir) pb_dir <= wbyte;
      if (wr_pe_dir) pe_dir <= wbyte & MASK_PE_DIR;
      if (wr_pk_dir) pk_dir <= wbyte & MASK_PK;
    end
  end

  // pull-up and drive-strength registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pullup_ctrl_reg <= RST_PULLUP;
      drive_strength_reg <= RST_DRIVE;
    end
    else
    begin
      if (wr_pullup) pullup_ctrl_reg <= next_pullup;
      if (wr_drive) drive_strength_reg <= wbyte & MASK_DRIVE;
    end
  end

  // read data; pull-up register hidden outside single-chip modes
  wire [7:0] pullup_view =
    single_chip_mode ? pullup_ctrl_reg : 8'h00;
  wire [7:0] pe_view =
    port_read(pe_dir, pe_data, pe_sync);
  wire [7:0] pk_view =
    port_read(pk_dir, pk_data, pk_sync) & MASK_PK;
  logic [7:0] read_byte;

  always_comb
  begin
    read_byte = 8'h00; // unmapped reads zero
    unique case (sel_q)
      SEL_PA_DATA: read_byte = port_read(pa_dir, pa_data, pa_sync);
      SEL_PB_DATA: read_byte = port_read(pb_dir, pb_data, pb_sync);
      SEL_PA_DIR: read_byte = pa_dir;
      SEL_PB_DIR: read_byte = pb_dir;
      SEL_PE_DATA: read_byte = pe_view;
      SEL_PE_DIR: read_byte = pe_dir;
      SEL_PULLUP: read_byte = pullup_view;
      SEL_DRIVE: read_byte = drive_strength_reg;
      SEL_PK_DATA: read_byte = pk_view;
      SEL_PK_DIR: read_byte = pk_dir;
      SEL_NONE: read_byte = 8'h00;
    endcase
  end

  // hrdata loaded in the wait state, held until the next read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      hrdata <= RST_RDATA;
    else if (do_read)
      hrdata <= {24'h000000, read_byte};
  end

  // named pull-up enables
  wire pk_pullup_en = pullup_ctrl_reg[BIT_PK_PULLUP];
  wire debug_pin_pullup_en = pullup_ctrl_reg[BIT_DEBUG_PULLUP];
  wire pe_pullup_en = pullup_ctrl_reg[BIT_PE_PULLUP];
  wire pb_pullup_en = pullup_ctrl_reg[BIT_PB_PULLUP];
  wire pa_pullup_en = pullup_ctrl_reg[BIT_PA_PULLUP];

  // named reduced-drive selects
  wire pk_weak_drive = drive_strength_reg[BIT_PK_WEAK];
  wire pe_weak_drive = drive_strength_reg[BIT_PE_WEAK];
  wire pb_weak_drive = drive_strength_reg[BIT_PB_WEAK];
  wire pa_weak_drive = drive_strength_reg[BIT_PA_WEAK];

  // a pin is an output when its direction bit or a peripheral drives it
  wire [7:0] pa_is_out = pa_dir | pa_periph_drive;
  wire [7:0] pb_is_out = pb_dir | pb_periph_drive;
  wire [7:0] pe_is_out = (pe_dir | pe_periph_drive) & MASK_PE_DIR;
  wire [7:0] pk_is_out = (pk_dir | pk_periph_drive) & MASK_PK;

  // general purpose pad drive; port e 1..0 are input only
  assign pa_out = pa_data;
  assign pb_out = pb_data;
  assign pe_out = pe_data;
  assign pk_out = pk_data;

  // output enables from the direction bits, low while driving
  assign pa_oe_n = ~pa_dir;
  assign pb_oe_n = ~pb_dir;
  assign pe_oe_n = ~pe_dir;
  assign pk_oe_n = ~pk_dir;

  // pull-ups only on input pins
  assign pk_pullup = {8{pk_pullup_en}} & ~pk_is_out & MASK_PK;
  assign pb_pullup = {8{pb_pullup_en}} & ~pb_is_out;
  assign pa_pullup = {8{pa_pullup_en}} & ~pa_is_out;
  assign pe_pullup =
    {8{pe_pullup_en}} & ~pe_is_out & ~MASK_PE_PULLDOWN;
  assign debug_pin_pullup =
    debug_pin_pullup_en && !debug_pin_drive;

  // pins 5 and 6 pull down straight from the reset pin, no flop delay
  assign pe_pulldown = nrst ? 8'h00 : MASK_PE_PULLDOWN;

  // reduced drive on outputs, whichever function drives them
  assign pk_reduced = {8{pk_weak_drive}} & pk_is_out;
  assign pe_reduced = {8{pe_weak_drive}} & pe_is_out;
  assign pb_reduced = {8{pb_weak_drive}} & pb_is_out;
  assign pa_reduced = {8{pa_weak_drive}} & pa_is_out;

  // hsize is accepted but only the low byte lane carries register data
  wire unused_ok = ^{hsize, hwdata[31:8], haddr[1:0]};

endmodule

`default_nettype wire
